/* File: dma_ctl_pkg.sv */
// Purpose: Shared constants and types for the DMA channel control block
// Assumes: One clock, synchronous reset, 32-bit register port
// Notes:   Offsets are byte addresses of word registers, channel n at base + 4*n
package dma_ctl_pkg;

	localparam int          NUM_CHANNELS = 4;

	// Register bases, four consecutive words each
	localparam logic [11:0] OFS_COUNT    = 12'h800;
	localparam logic [11:0] OFS_SOURCE   = 12'h810;
	localparam logic [11:0] OFS_TARGET   = 12'h820;
	localparam logic [11:0] OFS_NEXT     = 12'h830;
	localparam logic [11:0] OFS_CONTROL  = 12'h840;

	// Control field positions
	localparam int          BIT_EXT_SEL    = 0;
	localparam int          BIT_FLY_WRITE  = 1;
	localparam int          SRC_STEP_LO    = 2;
	localparam int          DST_STEP_LO    = 4;
	localparam int          BURST_LO       = 6;
	localparam int          BIT_CHAIN_DIS  = 9;
	localparam int          BIT_IRQ_POLICY = 10;
	localparam int          BIT_TRIGGER    = 11;
	localparam int          BIT_GO         = 12;
	localparam int          BIT_KICK       = 13;
	localparam int          BIT_ACTIVE     = 14;
	localparam int          BIT_ALIGN      = 15;
	localparam int          BIT_HOLDOFF    = 16;
	localparam int          BIT_CLOSE      = 17;
	localparam int          BIT_STOP_EN    = 18;
	localparam int          BIT_STOP_IRQ   = 19;
	localparam int          BIT_ABORT      = 20;
	localparam int          SRC_SPACE_LO   = 21;
	localparam int          DST_SPACE_LO   = 23;
	localparam int          REC_SPACE_LO   = 25;

	localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;
	localparam logic [31:0] CONTROL_WMASK  = 32'h07ef_bfff;
	localparam logic [1:0]  HOLDOFF_CYCLES = 2'h3;
	localparam logic [2:0]  BURST_MAX_CODE = 3'h6;

	localparam logic [1:0]  STEP_INC     = 2'b00;
	localparam logic [1:0]  STEP_DEC     = 2'b01;
	localparam logic [1:0]  STEP_HOLD    = 2'b10;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_WAIT  = 3'b001,
		ST_XFER  = 3'b010,
		ST_CLOSE = 3'b011,
		ST_FETCH = 3'b100
	} chan_state_t;

	typedef enum logic [1:0] {
		CMD_XFER  = 2'b00,
		CMD_CLOSE = 2'b01,
		CMD_FETCH = 2'b10
	} cmd_kind_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		cmd_kind_t   kind;
		logic [1:0]  chan;
		logic [31:0] src_addr;
		logic [31:0] dst_addr;
		logic [6:0]  len;
		logic [15:0] remain;
		logic        fifo_bypass;
		logic        sdram_write;
		logic [1:0]  src_step;
		logic [1:0]  dst_step;
		logic        align_dst;
		logic [1:0]  src_space;
		logic [1:0]  dst_space;
	} mem_cmd_t;

	typedef struct packed {
		logic [15:0] count;
		logic [31:0] src;
		logic [31:0] dst;
		logic [31:0] next;
	} record_t;

endpackage

/* File: pin_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous pins
// Assumes: Pins idle high, reset value matches
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             srst_in,
	// Pins and synchronised levels
	input  wire logic [WIDTH-1:0] pins_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			stage1   <= '1;
			sync_out <= '1;
		end else begin
			stage1   <= pins_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

/* File: dma_channel_control.sv */
// Purpose: Control logic of four DMA channels and their shared memory command port
// Assumes: Memory side answers each command with a one-cycle cmd_done_in
// Notes:   Lowest channel number wins the command port; no fairness
// Summary of operation
// - External select bypasses transfer FIFO
// - Fly-by direction: 0 read, 1 write SDRAM
// - Source address increments, decrements or holds
// - Target address increments, decrements or holds
// - Burst limited to power-of-two bytes
// - Chained mode loads next record at end
// - Completion pulse per count or chain end
// - Demand uses request pin, block ignores it
// - Go bit starts or disables channel
// - Kick forces record fetch, self-clears
// - Active flag reflects channel running
// - Alignment side passed with each burst
// - Request ignored three cycles after each burst completes
// - Close descriptor with remaining count
// - Stop pin ends transfer early
// - Stop event interrupt after FIFO drains or channel goes idle
// - Abort flushes leftover channel state
// - Space selects for source, target, record
// - Count decrements per burst, zero ends
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dma_channel_control (
	// Clock and reset
	input  wire logic                   ref_clk_in,
	input  wire logic                   srst_in,
	// Register port
	input  wire dma_ctl_pkg::reg_req_t  reg_in,
	output logic [31:0]                 rdata_out,
	// Device pins
	input  wire logic [3:0]             transfer_request_n_in,
	input  wire logic [3:0]             stop_pin_n_in,
	output logic [3:0]                  transfer_ack_n_out,
	input  wire logic [3:0]             timer_tc_in,
	// Memory command port
	output logic                        cmd_valid_out,
	output dma_ctl_pkg::mem_cmd_t       cmd_out,
	input  wire logic                   cmd_done_in,
	input  wire dma_ctl_pkg::record_t   record_in,
	input  wire logic [3:0]             fifo_empty_in,
	// Event pulses
	output logic [3:0]                  transfer_done_irq_out,
	output logic [3:0]                  stop_irq_out
);
	import dma_ctl_pkg::*;

	localparam int N = NUM_CHANNELS;

	logic        [31:0] control  [N];
	logic        [15:0] count    [N];
	logic        [31:0] src      [N];
	logic        [31:0] dst      [N];
	logic        [31:0] next_ptr [N];
	logic        [31:0] cur_rec  [N];
	chan_state_t        state    [N];
	logic        [1:0]  hold     [N];
	logic        [15:0] next_count [N];
	logic [N-1:0]       open_rec;
	logic [N-1:0]       have_rec;
	logic [N-1:0]       stop_pend;
	logic [N-1:0]       stop_irq_pend;
	logic [N-1:0]       done_c;
	logic [N-1:0]       stop_evt;
	logic [N-1:0]       stop_en_evt;
	logic [N-1:0]       kick_c;
	logic [N-1:0]       trig_c;
	logic [N-1:0]       need_close;
	logic [N-1:0]       more_rec;
	logic [N-1:0]       active_c;
	logic [N-1:0]       want;
	logic [3:0]         stop_prev;
	logic [3:0]         req_sync;
	logic [3:0]         stop_sync;
	logic               pick_valid;
	logic [1:0]         pick;
	mem_cmd_t           pick_cmd;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] base, input int c);
		return a[11:4] == base[11:4] && a[3:2] == 2'(c) && a[1:0] == 2'b00;
	endfunction

	function automatic logic [6:0] burst_len(input logic [2:0] code, input logic [15:0] cnt);
		logic [6:0] lim;
		lim = 7'h01 << ((code > BURST_MAX_CODE) ? BURST_MAX_CODE : code);
		return (cnt < {9'h000, lim}) ? cnt[6:0] : lim;
	endfunction

	function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] mode,
		input logic [6:0] len);
		unique case (mode)
			STEP_INC: return a + {25'h0, len};
			STEP_DEC: return a - {25'h0, len};
			default:  return a;
		endcase
	endfunction

	// Request and stop pins cross into the clock domain first
	pin_sync #(.WIDTH(8)) u_pins (
		.ref_clk_in (ref_clk_in),
		.srst_in    (srst_in),
		.pins_in    ({transfer_request_n_in, stop_pin_n_in}),
		.sync_out   ({req_sync, stop_sync})
	);

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			stop_prev <= 4'hf;
		end else begin
			stop_prev <= stop_sync;
		end
	end

	always_comb begin
		for (int c = 0; c < N; c++) begin
			done_c[c]      = cmd_done_in && cmd_valid_out && cmd_out.chan == 2'(c);
			stop_evt[c]    = stop_prev[c] && !stop_sync[c];
			stop_en_evt[c] = stop_evt[c] && control[c][BIT_STOP_EN] && state[c] != ST_IDLE;
			kick_c[c]      = control[c][BIT_KICK] && !control[c][BIT_CHAIN_DIS];
			trig_c[c]      = control[c][BIT_TRIGGER] ||
				((!req_sync[c] || timer_tc_in[c]) && hold[c] == 2'h0);
			need_close[c]  = open_rec[c] || (control[c][BIT_CLOSE] && have_rec[c]);
			more_rec[c]    = !control[c][BIT_CHAIN_DIS] && next_ptr[c] != 32'h0;
			active_c[c]    = state[c] != ST_IDLE;
			next_count[c]  = count[c] - {9'h000, cmd_out.len};
			want[c]        = (state[c] == ST_XFER || state[c] == ST_CLOSE ||
				state[c] == ST_FETCH) && !(cmd_valid_out && cmd_out.chan == 2'(c));
		end
	end

	always_comb begin
		pick_valid = 1'b0;
		pick       = 2'h0;
		for (int c = N - 1; c >= 0; c--) begin
			if (want[c]) begin
				pick_valid = 1'b1;
				pick       = 2'(c);
			end
		end
		pick_cmd             = '0;
		pick_cmd.chan        = pick;
		pick_cmd.kind        = (state[pick] == ST_FETCH) ? CMD_FETCH :
			(state[pick] == ST_CLOSE) ? CMD_CLOSE : CMD_XFER;
		pick_cmd.src_addr    = (state[pick] == ST_FETCH) ? next_ptr[pick] : src[pick];
		pick_cmd.dst_addr    = (state[pick] == ST_CLOSE) ? cur_rec[pick] : dst[pick];
		pick_cmd.len         = burst_len(control[pick][BURST_LO +: 3], count[pick]);
		pick_cmd.remain      = count[pick];
		pick_cmd.fifo_bypass = control[pick][BIT_EXT_SEL];
		pick_cmd.sdram_write = control[pick][BIT_EXT_SEL] && control[pick][BIT_FLY_WRITE];
		pick_cmd.src_step    = control[pick][SRC_STEP_LO +: 2];
		pick_cmd.dst_step    = control[pick][DST_STEP_LO +: 2];
		pick_cmd.align_dst   = control[pick][BIT_ALIGN];
		pick_cmd.src_space   = (state[pick] == ST_FETCH) ? control[pick][REC_SPACE_LO +: 2] :
			control[pick][SRC_SPACE_LO +: 2];
		pick_cmd.dst_space   = (state[pick] == ST_CLOSE) ? control[pick][REC_SPACE_LO +: 2] :
			control[pick][DST_SPACE_LO +: 2];
	end

	// Command port holds one command until the memory side answers
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			cmd_valid_out <= 1'b0;
			cmd_out       <= '0;
		end else if (cmd_valid_out) begin
			if (cmd_done_in) begin
				cmd_valid_out <= 1'b0;
			end
		end else if (pick_valid) begin
			cmd_valid_out <= 1'b1;
			cmd_out       <= pick_cmd;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		for (int c = 0; c < N; c++) begin
			if (srst_in) begin
				control[c]               <= CONTROL_RESET;
				count[c]                 <= 16'h0000;
				src[c]                   <= 32'h0;
				dst[c]                   <= 32'h0;
				next_ptr[c]              <= 32'h0;
				cur_rec[c]               <= 32'h0;
				state[c]                 <= ST_IDLE;
				hold[c]                  <= 2'h0;
				open_rec[c]              <= 1'b0;
				have_rec[c]              <= 1'b0;
				stop_pend[c]             <= 1'b0;
				stop_irq_pend[c]         <= 1'b0;
				transfer_done_irq_out[c] <= 1'b0;
				stop_irq_out[c]          <= 1'b0;
				transfer_ack_n_out[c]    <= 1'b1;
			end else begin
				transfer_done_irq_out[c] <= 1'b0;
				stop_irq_out[c]          <= 1'b0;
				transfer_ack_n_out[c]    <= !(state[c] == ST_XFER && !control[c][BIT_TRIGGER]);
				if (hold[c] != 2'h0) begin
					hold[c] <= hold[c] - 2'h1;
				end
				unique case (state[c])
					ST_IDLE: begin
						if (kick_c[c]) begin
							state[c] <= need_close[c] ? ST_CLOSE : ST_FETCH;
						end else if (control[c][BIT_GO] && count[c] != 16'h0000) begin
							state[c] <= ST_WAIT;
						end
					end
					ST_WAIT: begin
						if (kick_c[c] || stop_en_evt[c]) begin
							state[c] <= need_close[c] ? ST_CLOSE :
								(more_rec[c] ? ST_FETCH : ST_IDLE);
							if (!need_close[c] && !more_rec[c]) begin
								control[c][BIT_GO] <= 1'b0;
							end
						end else if (count[c] == 16'h0000) begin
							state[c] <= ST_IDLE;
						end else if (trig_c[c]) begin
							state[c] <= ST_XFER;
						end
					end
					ST_XFER: begin
						if (done_c[c]) begin
							// A finished record is not open, so a later kick closes only if the close bit is set
							open_rec[c]  <= next_count[c] != 16'h0000;
							stop_pend[c] <= 1'b0;
							count[c]     <= next_count[c];
							src[c]       <= step_addr(src[c], cmd_out.src_step, cmd_out.len);
							dst[c]       <= step_addr(dst[c], cmd_out.dst_step, cmd_out.len);
							if (control[c][BIT_HOLDOFF] && !control[c][BIT_TRIGGER]) begin
								hold[c] <= HOLDOFF_CYCLES - 2'h1;
							end
							if (next_count[c] == 16'h0000) begin
								transfer_done_irq_out[c] <= control[c][BIT_CHAIN_DIS] ||
									!control[c][BIT_IRQ_POLICY] || next_ptr[c] == 32'h0;
								state[c] <= more_rec[c] ? ST_FETCH : ST_IDLE;
							end else if (stop_pend[c] || kick_c[c] || stop_en_evt[c]) begin
								state[c] <= ST_CLOSE;
							end else begin
								state[c] <= ST_WAIT;
							end
						end else if (stop_en_evt[c]) begin
							stop_pend[c] <= 1'b1;
						end
					end
					ST_CLOSE: begin
						if (done_c[c]) begin
							open_rec[c] <= 1'b0;
							state[c]    <= (kick_c[c] || more_rec[c]) ? ST_FETCH : ST_IDLE;
							// no restart on the leftover count
							if (!kick_c[c] && !more_rec[c]) begin
								control[c][BIT_GO] <= 1'b0;
							end
						end
					end
					ST_FETCH: begin
						if (done_c[c]) begin
							count[c]            <= record_in.count;
							src[c]              <= record_in.src;
							dst[c]              <= record_in.dst;
							next_ptr[c]         <= record_in.next;
							cur_rec[c]          <= next_ptr[c];
							have_rec[c]         <= 1'b1;
							open_rec[c]         <= 1'b0;
							control[c][BIT_KICK] <= 1'b0;
							state[c]            <= (control[c][BIT_GO] &&
								record_in.count != 16'h0000) ? ST_WAIT : ST_IDLE;
						end
					end
					default: begin
						state[c] <= ST_IDLE;
					end
				endcase
				if (stop_irq_pend[c] && state[c] != ST_CLOSE &&
					(state[c] == ST_IDLE || fifo_empty_in[c])) begin
					stop_irq_out[c]  <= 1'b1;
					stop_irq_pend[c] <= 1'b0;
				end
				if (stop_evt[c] && control[c][BIT_STOP_IRQ]) begin
					stop_irq_pend[c] <= 1'b1;
				end
				if (reg_in.wr && hit(reg_in.addr, OFS_CONTROL, c)) begin
					// Kick is write-one so a set beats the self-clear
					control[c] <= (reg_in.wdata & CONTROL_WMASK) |
						({31'h0, control[c][BIT_KICK] && !(state[c] == ST_FETCH && done_c[c])}
						<< BIT_KICK);
					if (!reg_in.wdata[BIT_GO]) begin
						state[c]     <= ST_IDLE;
						stop_pend[c] <= 1'b0;
					end
					if (reg_in.wdata[BIT_ABORT]) begin
						open_rec[c]      <= 1'b0;
						have_rec[c]      <= 1'b0;
						stop_pend[c]     <= 1'b0;
						stop_irq_pend[c] <= 1'b0;
						hold[c]          <= 2'h0;
					end
				end
				if (reg_in.wr && hit(reg_in.addr, OFS_COUNT, c)) begin
					count[c] <= reg_in.wdata[15:0];
				end
				if (reg_in.wr && hit(reg_in.addr, OFS_SOURCE, c)) begin
					src[c] <= reg_in.wdata;
				end
				if (reg_in.wr && hit(reg_in.addr, OFS_TARGET, c)) begin
					dst[c] <= reg_in.wdata;
				end
				if (reg_in.wr && hit(reg_in.addr, OFS_NEXT, c)) begin
					next_ptr[c] <= reg_in.wdata;
				end
			end
		end
	end

	// Read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			rdata_out <= 32'h0;
		end else if (reg_in.rd) begin
			rdata_out <= 32'h0;
			for (int c = 0; c < N; c++) begin
				if (hit(reg_in.addr, OFS_COUNT, c)) begin
					rdata_out <= {16'h0000, count[c]};
				end
				if (hit(reg_in.addr, OFS_SOURCE, c)) begin
					rdata_out <= src[c];
				end
				if (hit(reg_in.addr, OFS_TARGET, c)) begin
					rdata_out <= dst[c];
				end
				if (hit(reg_in.addr, OFS_NEXT, c)) begin
					rdata_out <= next_ptr[c];
				end
				if (hit(reg_in.addr, OFS_CONTROL, c)) begin
					rdata_out <= (control[c] & ~(32'h1 << BIT_ACTIVE)) |
						({31'h0, active_c[c]} << BIT_ACTIVE);
				end
			end
		end
	end

	a_cmd_stable: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(cmd_valid_out && !cmd_done_in) |=> (cmd_valid_out && $stable(cmd_out)))
		else $error("command changed before answer");

	a_flyby_dir: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		cmd_valid_out |-> !(cmd_out.sdram_write && !cmd_out.fifo_bypass))
		else $error("sdram direction set without fly-by");

	for (genvar g = 0; g < N; g++) begin : g_chk
		a_holdoff_window: assert property (@(posedge ref_clk_in) disable iff (srst_in)
			(done_c[g] && state[g] == ST_XFER && control[g][BIT_HOLDOFF] &&
			!control[g][BIT_TRIGGER]) |=> (state[g] != ST_XFER) [*3])
			else $error("request honoured inside holdoff");

		a_block_start: assert property (@(posedge ref_clk_in) disable iff (srst_in)
			(state[g] == ST_WAIT && control[g][BIT_TRIGGER] && count[g] != 16'h0000 &&
			!kick_c[g] && !stop_en_evt[g] && !reg_in.wr) |=> state[g] == ST_XFER)
			else $error("block mode did not start");

		a_disable_idle: assert property (@(posedge ref_clk_in) disable iff (srst_in)
			(reg_in.wr && hit(reg_in.addr, OFS_CONTROL, g) && !reg_in.wdata[BIT_GO])
			|=> !active_c[g])
			else $error("channel active after disable");

		a_done_pulse: assert property (@(posedge ref_clk_in) disable iff (srst_in)
			(done_c[g] && state[g] == ST_XFER && next_count[g] == 16'h0000 &&
			(control[g][BIT_CHAIN_DIS] || !control[g][BIT_IRQ_POLICY]))
			|=> transfer_done_irq_out[g] ##1 !transfer_done_irq_out[g])
			else $error("completion pulse missing");

		a_done_masked: assert property (@(posedge ref_clk_in) disable iff (srst_in)
			(done_c[g] && state[g] == ST_XFER && next_count[g] == 16'h0000 &&
			!control[g][BIT_CHAIN_DIS] && control[g][BIT_IRQ_POLICY] &&
			next_ptr[g] != 32'h0) |=> !transfer_done_irq_out[g])
			else $error("completion pulse mid chain");

		a_stop_ignored: assert property (@(posedge ref_clk_in) disable iff (srst_in)
			(!control[g][BIT_STOP_EN] && !stop_pend[g]) |=> !stop_pend[g])
			else $error("stop pin taken while disabled");

		a_kick_clear: assert property (@(posedge ref_clk_in) disable iff (srst_in)
			(state[g] == ST_FETCH && done_c[g] && !(reg_in.wr &&
			hit(reg_in.addr, OFS_CONTROL, g))) |=> !control[g][BIT_KICK])
			else $error("kick not cleared after fetch");

		a_src_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in)
			(state[g] == ST_XFER && done_c[g] && cmd_out.src_step == STEP_HOLD &&
			!reg_in.wr) |=> $stable(src[g]))
			else $error("held source address moved");

		a_active_read: assert property (@(posedge ref_clk_in) disable iff (srst_in)
			(reg_in.rd && hit(reg_in.addr, OFS_CONTROL, g))
			|=> rdata_out[BIT_ACTIVE] == $past(active_c[g]))
			else $error("active flag readback wrong");
	end
endmodule
`default_nettype wire

/* File: dma_mem_model.sv */
// Purpose: Memory side stand-in answering channel commands
// Assumes: One command outstanding, answered after delay_in cycles
// Notes:   Record data outside the answer cycle is inverted to expose stale sampling
`timescale 1ns/100ps
`default_nettype none
module dma_mem_model (
	// Clock and reset
	input  wire logic                  ref_clk_in,
	input  wire logic                  srst_in,
	// Command side
	input  wire logic                  valid_in,
	input  wire logic [3:0]            delay_in,
	output logic                       done_out,
	output dma_ctl_pkg::record_t       record_out
);
	import dma_ctl_pkg::*;
	logic [3:0] wait_cnt;
	logic       answered;
	localparam record_t REC = '{count: 16'h0008, src: 32'h0000_2000, dst: 32'h0000_3000,
		next: 32'h0000_0000};
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || !valid_in) begin
			wait_cnt   <= 4'h0;
			answered   <= 1'b0;
			done_out   <= 1'b0;
			record_out <= srst_in ? '0 : ~record_out;
		end else if (!answered && wait_cnt == delay_in) begin
			answered   <= 1'b1;
			done_out   <= 1'b1;
			record_out <= REC;
		end else begin
			wait_cnt   <= wait_cnt + 4'h1;
			done_out   <= 1'b0;
			record_out <= ~record_out;
		end
	end
endmodule
`default_nettype wire

/* File: dma_channel_control_tb.sv */
// Purpose: Self-checking bench for the DMA channel control block
// Assumes: Memory side modelled by dma_mem_model
// Notes:   Demand mode exercised by request pin and timer; outputs sampled at the edge
`timescale 1ns/100ps
`default_nettype none
module dma_channel_control_tb;
	import dma_ctl_pkg::*;
	typedef struct { logic [2:0] code; logic [15:0] count; logic [31:0] extra; } row_t;
	row_t rows [5] = '{'{3'h0, 16'h0002, 32'h0120_0027}, '{3'h3, 16'h0008, 32'h0},
		'{3'h6, 16'h0064, 32'h00c0_0018}, '{3'h7, 16'h0046, 32'h0},
		'{3'h2, 16'h0005, 32'h0200_8000}};
	logic        clk;
	logic        srst;
	reg_req_t    reg_in;
	logic [31:0] rdata_out;
	logic [31:0] d;
	logic [31:0] ctl;
	logic [3:0]  req_n;
	logic [3:0]  stop_n;
	logic [3:0]  ack_n;
	logic [3:0]  dirq;
	logic [3:0]  sirq;
	logic [3:0]  fe;
	logic [3:0]  dly;
	logic [3:0]  tc;
	logic        cmd_valid;
	logic        done;
	mem_cmd_t    cmd;
	record_t     rec;
	logic [15:0] rem;
	logic [15:0] len;
	int          failures;
	int          checks_done;

	dma_channel_control dut_u (.ref_clk_in(clk), .srst_in(srst), .reg_in(reg_in),
		.rdata_out(rdata_out), .transfer_request_n_in(req_n), .stop_pin_n_in(stop_n),
		.transfer_ack_n_out(ack_n), .timer_tc_in(tc), .cmd_valid_out(cmd_valid),
		.cmd_out(cmd), .cmd_done_in(done), .record_in(rec), .fifo_empty_in(fe),
		.transfer_done_irq_out(dirq), .stop_irq_out(sirq));
	dma_mem_model mem_u (.ref_clk_in(clk), .srst_in(srst), .valid_in(cmd_valid),
		.delay_in(dly), .done_out(done), .record_out(rec));

	always #12.5 clk = ~clk;

	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		reg_in.wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		reg_in.rd <= 1'b0;
		@(posedge clk);
		v = rdata_out;
	endtask
	// Sel 0 command up, 1 command down, 2 completion pulse, 3 stop pulse
	task automatic wait_on(input int sel);
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			if ((sel == 0 && cmd_valid === 1'b1) || (sel == 1 && cmd_valid === 1'b0) ||
				(sel == 2 && dirq !== 4'h0) || (sel == 3 && sirq !== 4'h0)) return;
		end
		failures++;
		$display("[ERR] wait %0d expected 1 seen 0", sel);
		results();
	endtask
	task automatic burst(input cmd_kind_t k);
		wait_on(0);
		chk("kind", 32'(k), 32'(cmd.kind));
	endtask

	initial begin
		clk = 1'b0; srst = 1'b1; reg_in = '0; req_n = 4'hf; stop_n = 4'hf;
		fe = 4'hf; dly = 4'h0; failures = 0; checks_done = 0;
		tc = 4'h0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		foreach (rows[r]) begin
			ctl = 32'h0000_1a00 | rows[r].extra | (32'(rows[r].code) << 6);
			dly <= 4'(r);
			wr(OFS_CONTROL, 32'h0);
			wr(OFS_COUNT, 32'(rows[r].count));
			wr(OFS_SOURCE, 32'h0000_1000 + 32'(r));
			wr(OFS_TARGET, 32'h0000_5000);
			wr(OFS_CONTROL, ctl);
			rem = rows[r].count;
			while (rem != 16'h0) begin
				len = (rows[r].code > 3'h5) ? 16'd64 : (16'd1 << rows[r].code);
				if (len > rem) len = rem;
				burst(CMD_XFER);
				chk("len", 32'(len), 32'(cmd.len));
				chk("mode", 32'({ctl[1:0], ctl[5:2], ctl[15], ctl[24:21]}),
					32'({cmd.sdram_write, cmd.fifo_bypass, cmd.dst_step, cmd.src_step,
					cmd.align_dst, cmd.dst_space, cmd.src_space}));
				if (rem == rows[r].count) chk("src", 32'h1000 + 32'(r), cmd.src_addr);
				rem -= len;
				if (rem != 16'h0) wait_on(1);
			end
			wait_on(2);
			chk("done irq", 32'h1, 32'(dirq));
			rd(OFS_COUNT, d);
			chk("count", 32'h0, d);
			rd(OFS_CONTROL, d);
			chk("active", 32'h0, 32'(d[BIT_ACTIVE]));
		end
		// Demand mode: request pin, holdoff between bursts, then the timer
		wr(OFS_COUNT + 12'h4, 32'hc);
		wr(OFS_CONTROL + 12'h4, 32'h0001_1280);
		repeat (20) @(posedge clk);
		chk("no request", 32'h0, 32'(cmd_valid));
		rd(OFS_CONTROL + 12'h4, d);
		chk("active", 32'h1, 32'(d[BIT_ACTIVE]));
		req_n <= 4'hd;
		burst(CMD_XFER);
		chk("chan", 32'h1, 32'(cmd.chan));
		chk("ack", 32'hd, 32'(ack_n));
		wait_on(1);
		burst(CMD_XFER);
		req_n <= 4'hf;
		wait_on(1);
		repeat (8) @(posedge clk);
		chk("no timer", 32'h0, 32'(cmd_valid));
		tc <= 4'h2;
		burst(CMD_XFER);
		tc <= 4'h0;
		wait_on(2);
		chk("done irq", 32'h2, 32'(dirq));
		// Chained start by kick, end on null pointer
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_NEXT, 32'h10);
		wr(OFS_CONTROL, 32'h0000_3cc0);
		burst(CMD_FETCH);
		chk("record addr", 32'h10, cmd.src_addr);
		wait_on(1);
		burst(CMD_XFER);
		chk("len", 32'h8, 32'(cmd.len));
		chk("src", 32'h2000, cmd.src_addr);
		wr(OFS_NEXT, 32'h20);
		wait_on(1);
		chk("masked irq", 32'h0, 32'(dirq));
		burst(CMD_FETCH);
		chk("next record", 32'h20, cmd.src_addr);
		wait_on(1);
		burst(CMD_XFER);
		wait_on(2);
		chk("done irq", 32'h1, 32'(dirq));
		rd(OFS_CONTROL, d);
		chk("kick", 32'h0, 32'(d[BIT_KICK]));
		// Stop pin mid-transfer, fifo held busy so the interrupt waits for idle
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_COUNT, 32'h10);
		dly <= 4'h5;
		fe <= 4'he;
		wr(OFS_CONTROL, 32'h000e_1a80);
		burst(CMD_XFER);
		stop_n <= 4'he;
		wait_on(1);
		burst(CMD_CLOSE);
		chk("remain", 32'hc, 32'(cmd.remain));
		wait_on(3);
		chk("stop irq", 32'h1, 32'(sirq));
		rd(OFS_CONTROL, d);
		chk("stopped", 32'h0, 32'(d[BIT_ACTIVE]));
		stop_n <= 4'hf;
		fe <= 4'hf;
		// Second reset, reset values and refused bits
		srst <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		rd(OFS_CONTROL, d);
		chk("control reset", CONTROL_RESET, d);
		wr(12'h850, 32'hffff_ffff);
		rd(12'h850, d);
		chk("unmapped", 32'h0, d);
		wr(OFS_CONTROL + 12'hc, 32'hffff_cfff);
		rd(OFS_CONTROL + 12'hc, d);
		chk("control bits", 32'hffff_cfff & CONTROL_WMASK, d);
		results();
	end
endmodule
`default_nettype wire
